/* hdl/sfs_defines.svh */
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

`define SFS_CLK_MHZ 25
`define SFS_T_LIM_LONG_US 20000
`define SFS_T_LIM_SHORT_US 10000
`define SFS_T_RETRY_US 250000
`define SFS_T_REVBLK_US 100
`define SFS_T_SOFT_US 500
`define SFS_LIM_LONG_CYC (`SFS_T_LIM_LONG_US * `SFS_CLK_MHZ)
`define SFS_LIM_SHORT_CYC (`SFS_T_LIM_SHORT_US * `SFS_CLK_MHZ)
`define SFS_RETRY_CYC (`SFS_T_RETRY_US * `SFS_CLK_MHZ)
`define SFS_REVBLK_CYC (`SFS_T_REVBLK_US * `SFS_CLK_MHZ)
`define SFS_SOFT_CYC (`SFS_T_SOFT_US * `SFS_CLK_MHZ)

`define SFS_MUX_CURRENT 2'h0
`define SFS_MUX_OUTVOLT 2'h1
`define SFS_MUX_SYSVOLT 2'h2
`define SFS_UNUSED_RESULT 2'h3

`define SFS_ST1_SUPPLY_UNDERVOLTAGE_FLAG 0
`define SFS_ST1_SUPPLY_OVERVOLTAGE_FLAG 1
`define SFS_ST1_INPUT_UNDERVOLTAGE_FLAG 2
`define SFS_ST1_INPUT_OVERVOLTAGE_FLAG 3
`define SFS_ST1_ACC 4
`define SFS_ST1_LIMIT_RESISTOR_FAULT_FLAG 5
`define SFS_ST2_UV 0
`define SFS_ST2_OV 1
`define SFS_ST2_OC 2
`define SFS_ST2_TS 3
`define SFS_ST2_CH_WIDTH 4

`define SFS_SUPPLY_STATUS_REG_RESET 8'h00
`define SFS_CHANNEL_STATUS_REG_RESET 16'h0000
`define SFS_RESULT_RESET 8'h00

`endif

/* hdl/sfs_pkg.sv */
package sfs_pkg;
    typedef logic [1:0] sfs_mux_type;
    typedef struct packed {
        logic cur_limit;
        logic below_2v;
        logic out_uv;
        logic out_ov;
        logic hot;
        logic cooled;
    } sfs_chan_sense_type;
    typedef struct packed {
        logic in_uv;
        logic in_ov;
        logic vdd_uv;
        logic vdd_ov;
        logic limit_resistor_fault_flag_bad;
    } sfs_supply_sense_type;
    typedef struct packed {
        logic acc;
        logic ts;
        logic vdd;
        logic vin;
        logic oc;
        logic ov;
        logic uv;
    } sfs_mask_type;
    typedef struct packed {
        sfs_mux_type mux;
        logic [1:0] index;
    } sfs_adc_req_type;
    typedef enum logic [1:0] {CH_OFF, CH_SOFT, CH_ON, CH_HICCUP} sfs_ch_state_type;
    typedef enum logic [1:0] {AD_IDLE, AD_REQ, AD_WAIT} sfs_adc_state_type;
endpackage : sfs_pkg

/* hdl/sfs_channel.sv */
`timescale 1ns/10ps
`include "sfs_defines.svh"
module sfs_channel #(
    parameter int LIM_LONG_CYC = `SFS_LIM_LONG_CYC,
    parameter int LIM_SHORT_CYC = `SFS_LIM_SHORT_CYC,
    parameter int RETRY_CYC = `SFS_RETRY_CYC,
    parameter int SOFT_CYC = `SFS_SOFT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_req,
    input wire sfs_pkg::sfs_chan_sense_type sense,
    output logic main_on,
    output logic rev_on,
    output logic in_soft,
    output logic oc_trip,
    output logic thermal
);
    import sfs_pkg::*;
    sfs_ch_state_type state_reg, state_next;
    logic [23:0] tmr_reg, tmr_next;
    logic [23:0] lim_reg, lim_next;
    logic [11:0] rb_cnt_reg, rb_cnt_next;
    logic rb_off_reg, rb_off_next;
    logic ts_reg, ts_next;
    logic trip_reg, trip_next;
    logic ch_ok;
    logic running;
    logic trip;

    always_comb begin
        ts_next = sense.hot ? 1'b1 : (sense.cooled ? 1'b0 : ts_reg);
        ch_ok = enable_req && !ts_reg && !sense.hot;
        running = (state_reg == CH_SOFT) || (state_reg == CH_ON);
        lim_next = (running && sense.cur_limit) ? lim_reg + 24'h000001 : 24'h000000;
        trip = running && sense.cur_limit &&
            (lim_reg >= (sense.below_2v ? 24'(LIM_SHORT_CYC - 1) : 24'(LIM_LONG_CYC - 1)));
        state_next = state_reg;
        tmr_next = 24'h000000;
        trip_next = 1'b0;
        case (state_reg)
            CH_OFF: begin
                if (ch_ok && !sense.out_ov) begin
                    state_next = CH_SOFT;
                end
            end
            CH_SOFT, CH_ON: begin
                if (!ch_ok) begin
                    state_next = CH_OFF;
                end else if (trip) begin
                    state_next = CH_HICCUP;
                    trip_next = 1'b1;
                end else if (state_reg == CH_SOFT && tmr_reg == 24'(SOFT_CYC - 1)) begin
                    state_next = CH_ON;
                end else if (state_reg == CH_SOFT) begin
                    tmr_next = tmr_reg + 24'h000001;
                end
            end
            CH_HICCUP: begin
                if (!ch_ok) begin
                    state_next = CH_OFF;
                end else if (tmr_reg == 24'(RETRY_CYC - 1)) begin
                    state_next = CH_SOFT;
                end else begin
                    tmr_next = tmr_reg + 24'h000001;
                end
            end
            default: begin
                state_next = CH_OFF;
            end
        endcase
        rb_off_next = rb_off_reg;
        rb_cnt_next = 12'h000;
        if (!running) begin
            rb_off_next = 1'b0;
        end else if (!rb_off_reg) begin
            rb_off_next = sense.out_ov;
        end else if (rb_cnt_reg == 12'(`SFS_REVBLK_CYC - 1)) begin
            rb_off_next = sense.out_ov;
        end else begin
            rb_cnt_next = rb_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= CH_OFF;
            tmr_reg <= 24'h000000;
            lim_reg <= 24'h000000;
            rb_cnt_reg <= 12'h000;
            rb_off_reg <= 1'b0;
            ts_reg <= 1'b0;
            trip_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            lim_reg <= lim_next;
            rb_cnt_reg <= rb_cnt_next;
            rb_off_reg <= rb_off_next;
            ts_reg <= ts_next;
            trip_reg <= trip_next;
        end
    end

    assign main_on = (state_reg == CH_SOFT) || (state_reg == CH_ON);
    assign rev_on = main_on && !rb_off_reg;
    assign in_soft = (state_reg == CH_SOFT);
    assign oc_trip = trip_reg;
    assign thermal = ts_reg;
endmodule : sfs_channel

/* hdl/sfs_supervisor.sv */
`timescale 1ns/10ps
`include "sfs_defines.svh"
module sfs_supervisor #(
    parameter int LIM_LONG_CYC = `SFS_LIM_LONG_CYC,
    parameter int LIM_SHORT_CYC = `SFS_LIM_SHORT_CYC,
    parameter int RETRY_CYC = `SFS_RETRY_CYC,
    parameter int SOFT_CYC = `SFS_SOFT_CYC,
    parameter bit SAFETY_RATED = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic [3:0] channel_enable_bits,
    input wire sfs_pkg::sfs_mux_type mux_select,
    input wire logic continuous_conversion_select,
    input wire logic clear_on_read_select,
    input wire logic overvoltage_self_test,
    input wire sfs_pkg::sfs_mask_type int_mask,
    input wire logic supply_status_read,
    input wire logic channel_status_read,
    input wire logic result_one_read,
    input wire sfs_pkg::sfs_chan_sense_type [3:0] chan_sense,
    input wire sfs_pkg::sfs_supply_sense_type supply_sense,
    input wire logic adc_ready,
    input wire logic [7:0] adc_value,
    output logic [3:0] main_switch_on,
    output logic [3:0] reverse_fet_on,
    output logic [7:0] supply_status_reg,
    output logic [15:0] channel_status_reg,
    output logic [3:0][7:0] conversion_result_regs,
    output sfs_pkg::sfs_adc_req_type adc_request,
    output logic adc_start,
    output logic int_n_out,
    output logic int_n_oe
);
    import sfs_pkg::*;

    // supervision and channel state
    logic global_off;
    logic [3:0] enable_req;
    logic [3:0] ch_main;
    logic [3:0] ch_rev;
    logic [3:0] ch_soft;
    logic [3:0] ch_trip;
    logic [3:0] ch_ts;
    logic input_overvoltage_flag;
    logic input_undervoltage_flag;
    logic supply_overvoltage_flag;
    logic supply_undervoltage_flag;
    logic limit_resistor_fault_flag;
    logic [3:0] channel_overcurrent_flags;
    logic [3:0] channel_undervoltage_flags;
    logic [3:0] channel_overvoltage_flags;
    logic [3:0] channel_thermal_flags;
    logic [7:0] st1_live;
    logic [15:0] st2_live;
    logic [3:0] main_next;
    logic [3:0] rev_next;

    // status holding
    logic [7:0] st1_latch_reg, st1_latch_next;
    logic [15:0] st2_latch_reg, st2_latch_next;
    logic [7:0] st1_shown;
    logic [15:0] st2_shown;
    logic [7:0] st1_next;
    logic [15:0] st2_next;
    logic acc_reg, acc_next;
    logic int_next;
    logic [7:0] st1_int;
    logic [15:0] st2_int;

    // conversion sequencer
    sfs_adc_state_type ad_state_reg, ad_state_next;
    logic [1:0] ad_idx_reg, ad_idx_next;
    logic [3:0][7:0] result_next;
    logic adc_start_next;
    sfs_adc_req_type adc_req_next;
    sfs_mux_type eff_mux;
    logic ad_store;
    logic [7:0] ad_data;

    // the self-test overrides the four voltage comparators on the supplies; the limit resistor fault flag stays live
    always_comb begin
        input_overvoltage_flag = overvoltage_self_test ? 1'b1 : supply_sense.in_ov;
        supply_overvoltage_flag = overvoltage_self_test ? 1'b1 : supply_sense.vdd_ov;
        input_undervoltage_flag = overvoltage_self_test ? 1'b0 : supply_sense.in_uv;
        supply_undervoltage_flag = overvoltage_self_test ? 1'b0 : supply_sense.vdd_uv;
        limit_resistor_fault_flag = supply_sense.limit_resistor_fault_flag_bad;
        global_off = input_overvoltage_flag || input_undervoltage_flag ||
            supply_overvoltage_flag || supply_undervoltage_flag;
        enable_req = channel_enable_bits & {4{enable_pin && !global_off}};
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            sfs_channel #(
                .LIM_LONG_CYC(LIM_LONG_CYC),
                .LIM_SHORT_CYC(LIM_SHORT_CYC),
                .RETRY_CYC(RETRY_CYC),
                .SOFT_CYC(SOFT_CYC)
            ) u_ch (
                .clk(clk),
                .rst(rst),
                .enable_req(enable_req[gi]),
                .sense(chan_sense[gi]),
                .main_on(ch_main[gi]),
                .rev_on(ch_rev[gi]),
                .in_soft(ch_soft[gi]),
                .oc_trip(ch_trip[gi]),
                .thermal(ch_ts[gi])
            );
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            channel_overcurrent_flags[i] = ch_trip[i];
            channel_thermal_flags[i] = ch_ts[i];
            if (overvoltage_self_test) begin
                channel_overvoltage_flags[i] = 1'b1;
                channel_undervoltage_flags[i] = !ch_main[i];
            end else begin
                channel_overvoltage_flags[i] = chan_sense[i].out_ov;
                channel_undervoltage_flags[i] = !ch_main[i] || ch_soft[i] || chan_sense[i].out_uv;
            end
        end
        st1_live = `SFS_SUPPLY_STATUS_REG_RESET;
        st1_live[`SFS_ST1_SUPPLY_UNDERVOLTAGE_FLAG] = supply_undervoltage_flag;
        st1_live[`SFS_ST1_SUPPLY_OVERVOLTAGE_FLAG] = supply_overvoltage_flag;
        st1_live[`SFS_ST1_INPUT_UNDERVOLTAGE_FLAG] = input_undervoltage_flag;
        st1_live[`SFS_ST1_INPUT_OVERVOLTAGE_FLAG] = input_overvoltage_flag;
        st1_live[`SFS_ST1_LIMIT_RESISTOR_FAULT_FLAG] = limit_resistor_fault_flag;
        st2_live = `SFS_CHANNEL_STATUS_REG_RESET;
        for (int i = 0; i < 4; i++) begin
            st2_live[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_UV] = channel_undervoltage_flags[i];
            st2_live[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_OV] = channel_overvoltage_flags[i];
            st2_live[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_OC] = channel_overcurrent_flags[i];
            st2_live[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_TS] = channel_thermal_flags[i];
        end
        main_next = ch_main;
        rev_next = ch_rev;
    end

    // latched copies: a new event in the read cycle survives the clear
    always_comb begin
        st1_latch_next = st1_live | (supply_status_read ? `SFS_SUPPLY_STATUS_REG_RESET : st1_latch_reg);
        st2_latch_next = st2_live | (channel_status_read ? `SFS_CHANNEL_STATUS_REG_RESET : st2_latch_reg);
        acc_next = acc_reg && !result_one_read;
        if (ad_store && ad_idx_reg == 2'h3) begin
            acc_next = 1'b1;
        end
        st1_shown = clear_on_read_select ? st1_live : st1_latch_next;
        st2_shown = clear_on_read_select ? st2_live : st2_latch_next;
        st1_next = st1_shown;
        st1_next[`SFS_ST1_ACC] = acc_next;
        st2_next = st2_shown;
        st1_int = `SFS_SUPPLY_STATUS_REG_RESET;
        st1_int[`SFS_ST1_ACC] = acc_next && !int_mask.acc;
        st1_int[`SFS_ST1_SUPPLY_UNDERVOLTAGE_FLAG] = st1_shown[`SFS_ST1_SUPPLY_UNDERVOLTAGE_FLAG] && !int_mask.vdd;
        st1_int[`SFS_ST1_SUPPLY_OVERVOLTAGE_FLAG] = st1_shown[`SFS_ST1_SUPPLY_OVERVOLTAGE_FLAG] && !int_mask.vdd;
        st1_int[`SFS_ST1_INPUT_UNDERVOLTAGE_FLAG] = st1_shown[`SFS_ST1_INPUT_UNDERVOLTAGE_FLAG] && !int_mask.vin;
        st1_int[`SFS_ST1_INPUT_OVERVOLTAGE_FLAG] = st1_shown[`SFS_ST1_INPUT_OVERVOLTAGE_FLAG] && !int_mask.vin;
        st2_int = `SFS_CHANNEL_STATUS_REG_RESET;
        for (int i = 0; i < 4; i++) begin
            st2_int[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_UV] =
                st2_shown[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_UV] && !int_mask.uv;
            st2_int[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_OV] =
                st2_shown[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_OV] && !int_mask.ov;
            st2_int[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_OC] =
                st2_shown[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_OC] && !int_mask.oc;
            st2_int[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_TS] =
                st2_shown[i * `SFS_ST2_CH_WIDTH + `SFS_ST2_TS] && !int_mask.ts;
        end
        int_next = (|st1_int) || (|st2_int);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st1_latch_reg <= `SFS_SUPPLY_STATUS_REG_RESET;
            st2_latch_reg <= `SFS_CHANNEL_STATUS_REG_RESET;
            acc_reg <= 1'b0;
            supply_status_reg <= `SFS_SUPPLY_STATUS_REG_RESET;
            channel_status_reg <= `SFS_CHANNEL_STATUS_REG_RESET;
            main_switch_on <= 4'h0;
            reverse_fet_on <= 4'h0;
            int_n_out <= 1'b0;
            int_n_oe <= 1'b0;
        end else begin
            st1_latch_reg <= st1_latch_next;
            st2_latch_reg <= st2_latch_next;
            acc_reg <= acc_next;
            supply_status_reg <= st1_next;
            channel_status_reg <= st2_next;
            main_switch_on <= main_next;
            reverse_fet_on <= rev_next;
            int_n_out <= 1'b0;
            int_n_oe <= int_next;
        end
    end

    // conversion sequencer: four results in order, result four idle on mux 10
    always_comb begin
        eff_mux = SAFETY_RATED ? mux_select : `SFS_MUX_CURRENT;
        ad_state_next = ad_state_reg;
        ad_idx_next = ad_idx_reg;
        adc_start_next = 1'b0;
        adc_req_next = adc_request;
        result_next = conversion_result_regs;
        ad_store = 1'b0;
        ad_data = adc_value;
        case (ad_state_reg)
            AD_IDLE: begin
                if (continuous_conversion_select || result_one_read) begin
                    ad_state_next = AD_REQ;
                    ad_idx_next = 2'h0;
                end
            end
            AD_REQ: begin
                if (eff_mux == `SFS_MUX_SYSVOLT && ad_idx_reg == `SFS_UNUSED_RESULT) begin
                    ad_store = 1'b1;
                    ad_data = `SFS_RESULT_RESET;
                end else begin
                    adc_start_next = 1'b1;
                    adc_req_next.mux = eff_mux;
                    adc_req_next.index = ad_idx_reg;
                    ad_state_next = AD_WAIT;
                end
            end
            AD_WAIT: begin
                ad_store = adc_ready;
            end
            default: begin
                ad_state_next = AD_IDLE;
            end
        endcase
        if (ad_store) begin
            result_next[ad_idx_reg] = ad_data;
            if (ad_idx_reg == 2'h3) begin
                ad_state_next = continuous_conversion_select ? AD_REQ : AD_IDLE;
                ad_idx_next = 2'h0;
            end else begin
                ad_state_next = AD_REQ;
                ad_idx_next = ad_idx_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ad_state_reg <= AD_IDLE;
            ad_idx_reg <= 2'h0;
            adc_start <= 1'b0;
            adc_request <= '0;
            conversion_result_regs <= '0;
        end else begin
            ad_state_reg <= ad_state_next;
            ad_idx_reg <= ad_idx_next;
            adc_start <= adc_start_next;
            adc_request <= adc_req_next;
            conversion_result_regs <= result_next;
        end
    end
endmodule : sfs_supervisor

/* sim/sfs_adc_model.sv */
`timescale 1ns/10ps
module sfs_adc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic adc_start,
    input wire sfs_pkg::sfs_adc_req_type adc_request,
    output logic adc_ready,
    output logic [7:0] adc_value
);
    import sfs_pkg::*;
    sfs_adc_req_type req;
    logic [2:0] cnt;
    logic slow;
    // alternates fast and slow answers; data scrambled while idle
    always_ff @(posedge clk) begin
        adc_ready <= 1'b0;
        adc_value <= ~adc_value;
        if (rst) begin
            cnt <= 3'h0;
            slow <= 1'b0;
            adc_value <= 8'h00;
        end else if (adc_start) begin
            req <= adc_request;
            cnt <= slow ? 3'h6 : 3'h1;
            slow <= ~slow;
        end else if (cnt == 3'h1) begin
            cnt <= 3'h0;
            adc_ready <= 1'b1;
            adc_value <= {4'h5, req.mux, req.index};
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
endmodule : sfs_adc_model

/* sim/sfs_supervisor_checker.sv */
`timescale 1ns/10ps
module sfs_supervisor_checker #(
    parameter int LIM_LONG_CYC = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic overvoltage_self_test,
    input wire sfs_pkg::sfs_mask_type int_mask,
    input wire sfs_pkg::sfs_chan_sense_type [3:0] chan_sense,
    input wire sfs_pkg::sfs_supply_sense_type supply_sense,
    input wire logic [3:0] main_switch_on,
    input wire logic [7:0] supply_status_reg,
    input wire logic [15:0] channel_status_reg,
    input wire sfs_pkg::sfs_adc_req_type adc_request,
    input wire logic adc_start,
    input wire logic int_n_oe
);
    import sfs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] lim_cnt_reg;
    logic [31:0] lim_cnt_next;
    always_comb begin
        lim_cnt_next = 32'h0;
        if (chan_sense[0].cur_limit && main_switch_on[0]) begin
            lim_cnt_next = lim_cnt_reg + 32'h1;
        end
    end
    always_ff @(posedge clk) begin
        lim_cnt_reg <= rst ? 32'h0 : lim_cnt_next;
    end
    chk_enable_gate: assert property (!enable_pin |-> ##2 main_switch_on == 4'h0)
        else $error("channel on without enable pin");
    chk_supply_off: assert property ((|supply_sense[4:1]) |-> ##2 main_switch_on == 4'h0)
        else $error("channel on during supply fault");
    chk_uv_when_off: assert property (!main_switch_on[0] [*3] |-> channel_status_reg[0])
        else $error("undervoltage flag low on open switch");
    chk_limit_time: assert property (lim_cnt_reg <= LIM_LONG_CYC + 4)
        else $error("current limit held too long");
    chk_test_ov_set: assert property (overvoltage_self_test [*3] |->
        supply_status_reg[3] && supply_status_reg[1] && (channel_status_reg & 16'h2222) == 16'h2222)
        else $error("self-test overvoltage flags missing");
    chk_test_uv_hide: assert property (overvoltage_self_test [*3] |-> supply_status_reg[2:0] == 3'h2)
        else $error("undervoltage reported in self-test");
    chk_thermal_off: assert property (chan_sense[2].hot |-> ##2 !main_switch_on[2])
        else $error("hot channel still on");
    chk_mux_skip: assert property (adc_start && adc_request.mux == 2'h2 |-> adc_request.index != 2'h3)
        else $error("fourth result converted in system mode");
    chk_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    chk_int_unmasked: assert property (int_mask == 7'h00 && channel_status_reg != 16'h0 |-> int_n_oe)
        else $error("interrupt idle with fault present");
endmodule : sfs_supervisor_checker

bind sfs_supervisor sfs_supervisor_checker #(.LIM_LONG_CYC(LIM_LONG_CYC)) u_chk (.clk, .rst, .enable_pin,
    .overvoltage_self_test, .int_mask, .chan_sense, .supply_sense, .main_switch_on, .supply_status_reg,
    .channel_status_reg, .adc_request, .adc_start, .int_n_oe);

/* sim/switch_fault_supervisor_test.sv */
`timescale 1ns/10ps
module switch_fault_supervisor_test;
    import sfs_pkg::*;
    localparam int LL = 200;
    localparam int LS = 100;
    localparam int RT = 300;
    localparam int SC = 20;
    typedef struct packed {sfs_mux_type m; logic [31:0] r;} sfs_row_type;
    sfs_row_type rows [3] = '{'{2'h0, 32'h53525150}, '{2'h1, 32'h57565554}, '{2'h2, 32'h005A5958}};
    logic [7:0] sup_exp [5] = '{8'h20, 8'h02, 8'h01, 8'h08, 8'h04};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable_pin = 1'b0;
    logic [3:0] ch_en = 4'h0;
    sfs_mux_type mux = 2'h0;
    logic cont = 1'b0;
    logic clr = 1'b1;
    logic ovt = 1'b0;
    sfs_mask_type mask = '0;
    logic rd_s = 1'b0;
    logic rd_c = 1'b0;
    logic rd_r = 1'b0;
    sfs_chan_sense_type [3:0] cs = '0;
    sfs_supply_sense_type ss = '0;
    logic adc_ready;
    logic [7:0] adc_value;
    logic [3:0] main_on;
    logic [3:0] rev_on;
    logic [7:0] st1;
    logic [15:0] st2;
    logic [3:0][7:0] res;
    sfs_adc_req_type adc_request;
    logic adc_start;
    logic int_oe;
    logic int_do;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    sfs_supervisor #(.LIM_LONG_CYC(LL), .LIM_SHORT_CYC(LS), .RETRY_CYC(RT), .SOFT_CYC(SC)) u_dut (
        .clk, .rst, .enable_pin, .channel_enable_bits(ch_en), .mux_select(mux),
        .continuous_conversion_select(cont), .clear_on_read_select(clr), .overvoltage_self_test(ovt),
        .int_mask(mask), .supply_status_read(rd_s), .channel_status_read(rd_c), .result_one_read(rd_r),
        .chan_sense(cs), .supply_sense(ss), .adc_ready, .adc_value, .main_switch_on(main_on),
        .reverse_fet_on(rev_on), .supply_status_reg(st1), .channel_status_reg(st2),
        .conversion_result_regs(res), .adc_request, .adc_start, .int_n_out(int_do), .int_n_oe(int_oe));
    sfs_adc_model u_adc (.clk, .rst, .adc_start, .adc_request, .adc_ready, .adc_value);
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic rd_stat();
        rd_s = 1'b1;
        rd_c = 1'b1;
        tick(1);
        rd_s = 1'b0;
        rd_c = 1'b0;
        tick(1);
    endtask : rd_stat
    task automatic wait_on(input int i, input logic v, input int lim, output int k);
        k = 0;
        while (main_on[i] !== v && k < lim) begin
            tick(1);
            k++;
        end
    endtask : wait_on
    initial begin
        tick(6);
        chk("reset_out", {main_on, rev_on, 6'h0, int_do, int_oe}, 32'h0);
        chk("reset_res", res, 32'h0);
        rst = 1'b0;
        tick(2);
        foreach (rows[i]) begin
            mux = rows[i].m;
            tick(2);
            rd_r = 1'b1;
            tick(1);
            rd_r = 1'b0;
            tick(3);
            n = 0;
            while (st1[4] !== 1'b1 && n < 300) begin
                tick(1);
                n++;
            end
            chk("results", res, rows[i].r);
        end
        cont = 1'b1;
        n = 0;
        repeat (80) begin
            tick(1);
            n += int'(adc_start === 1'b1);
        end
        chk("repeat", n >= 4, 1);
        cont = 1'b0;
        tick(30);
        ch_en = 4'hF;
        tick(10);
        chk("pin_low", main_on, 4'h0);
        enable_pin = 1'b1;
        ch_en = 4'h5;
        tick(SC + 6);
        chk("bits_only", main_on, 4'h5);
        chk("uv_open", st2 & 16'h1111, 16'h1010);
        ch_en = 4'hF;
        tick(6);
        chk("uv_soft", st2[4], 1'b1);
        tick(SC + 6);
        chk("uv_on", st2 & 16'h1111, 16'h0);
        cs[2].hot = 1'b1;
        tick(4);
        chk("hot_off", main_on, 4'hB);
        chk("ts_flag", st2[11], 1'b1);
        cs[2].hot = 1'b0;
        tick(SC + 10);
        chk("not_cooled", main_on, 4'hB);
        cs[2].cooled = 1'b1;
        tick(2);
        cs[2].cooled = 1'b0;
        tick(SC + 8);
        chk("cooled_on", main_on, 4'hF);
        for (int k = 0; k < 5; k++) begin
            ss = 5'h01 << k;
            tick(4);
            chk("supply_flag", st1 & 8'h2F, sup_exp[k]);
            if (k > 0) chk("supply_off", main_on, 4'h0);
            ss = '0;
            tick(SC + 8);
        end
        chk("supply_back", main_on, 4'hF);
        clr = 1'b0;
        for (int j = 0; j < 2; j++) begin
            cs[0].below_2v = (j == 0);
            cs[0].cur_limit = 1'b1;
            wait_on(0, 1'b0, LL + 20, n);
            chk("limit_time", n >= (j == 0 ? LS : LL) && n <= (j == 0 ? LS : LL) + 4, 1);
            cs[0].cur_limit = 1'b0;
            tick(5);
            chk("oc_latched", st2[2], 1'b1);
            chk("uv_in_wait", st2[0], 1'b1);
            rd_stat();
            tick(2);
            chk("oc_cleared", st2[2], 1'b0);
            wait_on(0, 1'b1, RT + 20, n);
            chk("retry_time", n >= RT - 15 && n <= RT + 2, 1);
            tick(SC + 4);
        end
        clr = 1'b1;
        ch_en = 4'hD;
        tick(SC);
        cs[1].out_ov = 1'b1;
        tick(2);
        ch_en = 4'hF;
        tick(SC + 6);
        chk("stb_before", main_on[1], 1'b0);
        cs[1].out_ov = 1'b0;
        tick(SC + 8);
        chk("stb_cleared", {main_on[1], rev_on[1]}, 2'h3);
        cs[1].out_ov = 1'b1;
        tick(4);
        chk("stb_after", {main_on, rev_on}, 8'hFD);
        chk("ov_flag", st2[5], 1'b1);
        tick(2600);
        chk("stb_held", {main_on, rev_on}, 8'hFD);
        chk("ov_steady", st2[5], 1'b1);
        cs[1].out_ov = 1'b0;
        n = 0;
        while (rev_on[1] !== 1'b1 && n < 2600) begin
            tick(1);
            n++;
        end
        chk("stb_back", {main_on, rev_on}, 8'hFF);
        ch_en = 4'h0;
        tick(SC);
        ovt = 1'b1;
        ss.in_uv = 1'b1;
        tick(4);
        rd_stat();
        chk("test_st1", st1 & 8'h0F, 8'h0A);
        chk("test_st2", st2 & 16'h3333, 16'h3333);
        ovt = 1'b0;
        ss = '0;
        clr = 1'b0;
        mask = 7'h7D;
        tick(4);
        rd_stat();
        tick(2);
        chk("int_idle", int_oe, 1'b0);
        cs[3].out_ov = 1'b1;
        tick(3);
        cs[3].out_ov = 1'b0;
        tick(4);
        chk("int_latched", {int_oe, st2[13]}, 2'h3);
        rd_stat();
        tick(2);
        chk("int_read", int_oe, 1'b0);
        mask = 7'h7F;
        cs[3].out_ov = 1'b1;
        tick(3);
        chk("int_masked", int_oe, 1'b0);
        cs[3].out_ov = 1'b0;
        clr = 1'b1;
        mask = 7'h7D;
        tick(3);
        cs[3].out_ov = 1'b1;
        tick(3);
        chk("int_live", {int_oe, int_do}, 2'h2);
        cs[3].out_ov = 1'b0;
        tick(3);
        chk("int_live_off", int_oe, 1'b0);
        print_verdict();
    end
endmodule : switch_fault_supervisor_test
